// File: common/xbs_pkg.sv
// constants, address decode and priority tables for the crossbar switch
// assumes a single clock domain; every master and target is sampled on REF_CLK
package xbs_pkg;

    // sizes
    localparam int NUM_MASTERS  = 4;
    localparam int NUM_TARGETS  = 5;
    localparam int ADDR_W       = 32;
    localparam int DATA_W       = 32;
    localparam int BRIDGE_DEPTH = 4;

    // master indices
    localparam logic [1:0] MST_CPU_DATA  = 2'h0;
    localparam logic [1:0] MST_PROG_FILL = 2'h1;
    localparam logic [1:0] MST_DMA_HIGH  = 2'h2;
    localparam logic [1:0] MST_DMA_LOW   = 2'h3;

    // target group codes
    localparam logic [2:0] TGT_ONCHIP = 3'h0;
    localparam logic [2:0] TGT_EXTMEM = 3'h1;
    localparam logic [2:0] TGT_PERIPH = 3'h2;
    localparam logic [2:0] TGT_AUDIO  = 3'h3;
    localparam logic [2:0] TGT_DMACFG = 3'h4;
    localparam logic [2:0] TGT_NONE   = 3'h7;

    // address regions (top nibble, or top byte for the audio ports)
    localparam logic [3:0] REGION_ROM      = 4'h0;
    localparam logic [3:0] REGION_RAM      = 4'h1;
    localparam logic [3:0] REGION_PERIPH   = 4'h4;
    localparam logic [3:0] REGION_DMACFG   = 4'h6;
    localparam logic [3:0] REGION_SDRAM    = 4'h8;
    localparam logic [3:0] REGION_ASYNC    = 4'h9;
    localparam logic [7:0] AUDIO_FIRST     = 8'h54;
    localparam logic [7:0] AUDIO_LAST      = 8'h56;

    // bridge configuration register
    localparam logic [31:0] BRIDGE_CONFIG_ADDR   = 32'h40000024;
    localparam int          SLAVE_BRIDGE_RST_BIT = 0;
    localparam logic        SLAVE_BRIDGE_RST_RV  = 1'b1;

    // rank value meaning no candidate
    localparam logic [2:0] RANK_NONE = 3'h7;

    // which target group an address belongs to
    function automatic logic [2:0] target_of(input logic [31:0] addr);
        if (addr[31:28] == REGION_ROM || addr[31:28] == REGION_RAM) begin
            return TGT_ONCHIP;
        end else if (addr[31:28] == REGION_SDRAM || addr[31:28] == REGION_ASYNC) begin
            return TGT_EXTMEM;
        end else if (addr[31:28] == REGION_PERIPH) begin
            return TGT_PERIPH;
        end else if (addr[31:24] >= AUDIO_FIRST && addr[31:24] <= AUDIO_LAST) begin
            return TGT_AUDIO;
        end else if (addr[31:28] == REGION_DMACFG) begin
            return TGT_DMACFG;
        end else begin
            return TGT_NONE;
        end
    endfunction

    // wiring of the switch: program fill only reaches external memory,
    // the cpu data port reaches on-chip memory through its own controller
    function automatic logic reachable(input logic [1:0] m, input logic [2:0] t);
        if (m == MST_PROG_FILL) begin
            return t == TGT_EXTMEM;
        end else if (m == MST_CPU_DATA) begin
            return t != TGT_ONCHIP && t != TGT_NONE;
        end else begin
            return t != TGT_NONE;
        end
    endfunction

    // fixed rank, 1 wins; program fill sits fourth at external memory
    function automatic logic [2:0] rank_of(input logic [2:0] t, input logic [1:0] m);
        if (m == MST_CPU_DATA) begin
            return 3'h1;
        end else if (m == MST_DMA_HIGH) begin
            return 3'h2;
        end else if (m == MST_DMA_LOW) begin
            return 3'h3;
        end else if (t == TGT_EXTMEM) begin
            return 3'h4;
        end else begin
            return RANK_NONE;
        end
    endfunction

endpackage

// File: verilog/xbs_bridge.sv
// bus bridge: small fifo with a registered output stage
// assumes DEPTH >= 1; a synchronous reset empties it, ce low freezes it
`timescale 1ns/1ps
module xbs_bridge #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 4
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PW-1:0]    wr_ptr, next_wr_ptr;
    logic [PW-1:0]    rd_ptr, next_rd_ptr;
    logic [CW-1:0]    count, next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push, pop;

    // full is honest: the filling side sees back-pressure once DEPTH words wait
    assign in_ready = (count != FULL_CNT);

    // accept at the master's pace, drain at the target's pace
    always_comb begin
        push           = in_valid && in_ready;
        pop            = (count != '0) && (!out_valid || out_ready);
        next_mem       = mem;
        next_wr_ptr    = wr_ptr;
        next_rd_ptr    = rd_ptr;
        next_out_valid = out_valid && !out_ready;
        next_out_data  = out_data;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr      = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_out_valid = 1'b1;
            next_out_data  = mem[rd_ptr];
            next_rd_ptr    = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
        end
        next_count = count + CW'(push) - CW'(pop);
    end

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (ce) begin
            mem       <= next_mem;
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end
endmodule

// File: verilog/xbs_crossbar.sv
// crossbar switch: four masters, five target groups, one bridge per target
// assumes masters hold request and attributes until acknowledged and that
// each target pulses T_DONE once per command it has taken
`timescale 1ns/1ps
module xbs_crossbar
    import xbs_pkg::*;
#(
    parameter int DEPTH = BRIDGE_DEPTH
) (
    // clock, reset, enable
    input  wire logic                          REF_CLK,
    input  wire logic                          RESET,
    input  wire logic                          CE,
    // master request side, master m in slice m
    input  wire logic [NUM_MASTERS-1:0]        M_REQ,
    input  wire logic [NUM_MASTERS*ADDR_W-1:0] M_ADDR,
    input  wire logic [NUM_MASTERS-1:0]        M_WE,
    input  wire logic [NUM_MASTERS*DATA_W-1:0] M_WDATA,
    // master answer side
    output logic [NUM_MASTERS-1:0]             M_ACK,
    output logic [NUM_MASTERS*DATA_W-1:0]      M_RDATA,
    // target command side, target t in slice t
    output logic [NUM_TARGETS-1:0]             T_REQ,
    output logic [NUM_TARGETS*ADDR_W-1:0]      T_ADDR,
    output logic [NUM_TARGETS-1:0]             T_WE,
    output logic [NUM_TARGETS*DATA_W-1:0]      T_WDATA,
    input  wire logic [NUM_TARGETS-1:0]        T_ACCEPT,
    // target completion side
    input  wire logic [NUM_TARGETS-1:0]        T_DONE,
    input  wire logic [NUM_TARGETS*DATA_W-1:0] T_RDATA,
    // bridge reset state, a copy of the config bit
    output logic                               SLAVE_BRIDGE_RESET
);
    localparam int CMD_W = 1 + ADDR_W + DATA_W;

    // ownership per target
    logic [NUM_TARGETS-1:0]        owner_vld, next_owner_vld;
    logic [1:0]                    owner     [NUM_TARGETS];
    logic [1:0]                    next_owner[NUM_TARGETS];
    // answers to masters
    logic [NUM_MASTERS-1:0]        next_ack;
    logic [NUM_MASTERS*DATA_W-1:0] next_rdata;
    // bridge configuration bit
    logic                          bridge_config_rst, next_bridge_config_rst;
    // bridge fill side
    logic [NUM_TARGETS-1:0]        push, in_ready;
    logic [CMD_W-1:0]              push_cmd  [NUM_TARGETS];
    // combinational helpers
    logic [2:0]                    m_tgt     [NUM_MASTERS];
    logic [NUM_MASTERS-1:0]        req_eff, busy;
    logic [2:0]                    best_rank;
    logic [1:0]                    best;
    logic                          found;
    logic [ADDR_W-1:0]             g_addr;

    // address decode of every master
    always_comb begin
        for (int m = 0; m < NUM_MASTERS; m++) begin
            m_tgt[m] = target_of(M_ADDR[m*ADDR_W +: ADDR_W]);
        end
    end

    // arbitration, ownership, completion and the config register
    always_comb begin
        next_owner_vld         = owner_vld;
        next_owner             = owner;
        next_ack               = '0;
        next_rdata             = M_RDATA;
        next_bridge_config_rst = bridge_config_rst;
        push                   = '0;
        busy                   = '0;
        best_rank              = RANK_NONE;
        best                   = 2'h0;
        found                  = 1'b0;
        g_addr                 = '0;
        for (int t = 0; t < NUM_TARGETS; t++) begin
            push_cmd[t] = '0;
            if (owner_vld[t]) begin
                busy[owner[t]] = 1'b1;
            end
        end
        // a master in flight or being answered this cycle is not re-arbitrated
        req_eff = M_REQ & ~M_ACK & ~busy;

        // completion frees the target only after the access is done
        for (int t = 0; t < NUM_TARGETS; t++) begin
            if (owner_vld[t] && T_DONE[t]) begin
                next_ack[owner[t]]                    = 1'b1;
                next_rdata[owner[t]*DATA_W +: DATA_W] = T_RDATA[t*DATA_W +: DATA_W];
                next_owner_vld[t]                     = 1'b0;
            end
        end

        // one independent arbiter per target, so distinct targets never stall
        for (int t = 0; t < NUM_TARGETS; t++) begin
            best_rank = RANK_NONE;
            best      = 2'h0;
            found     = 1'b0;
            for (int m = 0; m < NUM_MASTERS; m++) begin
                // lowest rank wins; cpu 1, high dma 2, low dma 3, fill 4
                if (req_eff[m] && m_tgt[m] == 3'(t) && reachable(2'(m), 3'(t))
                    && rank_of(3'(t), 2'(m)) < best_rank) begin
                    best_rank = rank_of(3'(t), 2'(m));
                    best      = 2'(m);
                    found     = 1'b1;
                end
            end
            g_addr = M_ADDR[best*ADDR_W +: ADDR_W];
            if (found && 3'(t) == TGT_PERIPH && g_addr == BRIDGE_CONFIG_ADDR) begin
                // the config register answers locally; reserved bits read zero
                next_ack[best] = 1'b1;
                if (M_WE[best]) begin
                    next_bridge_config_rst = M_WDATA[best*DATA_W + SLAVE_BRIDGE_RST_BIT];
                end else begin
                    next_rdata[best*DATA_W +: DATA_W] = DATA_W'(bridge_config_rst);
                end
            end else if (found && !owner_vld[t] && in_ready[t]
                         && !(3'(t) == TGT_ONCHIP && bridge_config_rst)) begin
                // losers and masters facing a held bridge simply wait
                push[t]           = 1'b1;
                push_cmd[t]       = {M_WE[best], g_addr, M_WDATA[best*DATA_W +: DATA_W]};
                next_owner_vld[t] = 1'b1;
                next_owner[t]     = best;
            end
        end

        // unmapped or unwired address: answer at once with zero data
        for (int m = 0; m < NUM_MASTERS; m++) begin
            if (req_eff[m] && !reachable(2'(m), m_tgt[m])) begin
                next_ack[m]                    = 1'b1;
                next_rdata[m*DATA_W +: DATA_W] = '0;
            end
        end
    end

    // registers only
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            owner_vld          <= '0;
            M_ACK              <= '0;
            M_RDATA            <= '0;
            bridge_config_rst  <= SLAVE_BRIDGE_RST_RV;
            SLAVE_BRIDGE_RESET <= SLAVE_BRIDGE_RST_RV;
            for (int t = 0; t < NUM_TARGETS; t++) begin
                owner[t] <= 2'h0;
            end
        end else if (CE) begin
            owner_vld          <= next_owner_vld;
            owner              <= next_owner;
            M_ACK              <= next_ack;
            M_RDATA            <= next_rdata;
            bridge_config_rst  <= next_bridge_config_rst;
            SLAVE_BRIDGE_RESET <= next_bridge_config_rst;
        end
    end

    // one bridge in front of each target; the on-chip one obeys the config bit.
    // a held bridge drops anything queued, which is why software must not
    // assert the bit with dma traffic in flight
    for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_bridge
        logic             b_rst;
        logic [CMD_W-1:0] b_out;
        assign b_rst = (t == 0) ? (RESET || bridge_config_rst) : RESET;
        xbs_bridge #(
            .WIDTH (CMD_W),
            .DEPTH (DEPTH)
        ) u_bridge (
            .clk       (REF_CLK),
            .rst       (b_rst),
            .ce        (CE),
            .in_valid  (push[t]),
            .in_ready  (in_ready[t]),
            .in_data   (push_cmd[t]),
            .out_valid (T_REQ[t]),
            .out_ready (T_ACCEPT[t]),
            .out_data  (b_out)
        );
        assign T_WE[t]                      = b_out[CMD_W-1];
        assign T_ADDR[t*ADDR_W +: ADDR_W]   = b_out[DATA_W +: ADDR_W];
        assign T_WDATA[t*DATA_W +: DATA_W]  = b_out[DATA_W-1:0];
    end
endmodule

// File: sim/xbs_crossbar_props.sv
// checker for the crossbar switch, watching only its ports
// assumes one clock REF_CLK and a synchronous active-high RESET
`timescale 1ns/1ps
module xbs_crossbar_props
    import xbs_pkg::*;
(
    // clock and reset
    input wire logic                          REF_CLK,
    input wire logic                          RESET,
    // master side
    input wire logic [NUM_MASTERS-1:0]        M_REQ,
    input wire logic [NUM_MASTERS-1:0]        M_ACK,
    // target side
    input wire logic [NUM_TARGETS-1:0]        T_REQ,
    input wire logic [NUM_TARGETS*ADDR_W-1:0] T_ADDR,
    input wire logic [NUM_TARGETS-1:0]        T_ACCEPT,
    input wire logic [NUM_TARGETS-1:0]        T_DONE,
    input wire logic                          SLAVE_BRIDGE_RESET
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // a command offered to target t, taken or still waiting
    sequence s_taken(int t);
        T_REQ[t] && T_ACCEPT[t];
    endsequence
    sequence s_waiting(int t);
        T_REQ[t] && !T_ACCEPT[t];
    endsequence

    // reset clears traffic and holds the on-chip bridge
    reset_state_a: assert property (disable iff (1'b0) RESET |=> SLAVE_BRIDGE_RESET && T_REQ == '0 && M_ACK == '0)
        else $error("state after reset is wrong");
    // nothing reaches on-chip memory while its bridge is held
    onchip_block_a: assert property (SLAVE_BRIDGE_RESET && $past(SLAVE_BRIDGE_RESET) |-> !T_REQ[0])
        else $error("on-chip command while bridge held");

    // per master: acks are single pulses answering a held request
    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_mst
        ack_pulse_a: assert property (M_ACK[m] |=> !M_ACK[m])
            else $error("ack longer than one cycle");
        ack_cause_a: assert property (M_ACK[m] |-> $past(M_REQ[m]))
            else $error("ack without request");
    end

    // per target: commands held until taken, owner kept until done
    for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_tgt
        cmd_hold_a: assert property (s_waiting(t) |=> T_REQ[t] && $stable(T_ADDR[t*ADDR_W +: ADDR_W]))
            else $error("waiting command dropped or changed");
        owner_keep_a: assert property (s_taken(t) |=> !T_REQ[t])
            else $error("new command before the access completed");
        done_ack_a: assert property (T_DONE[t] |=> M_ACK != '0)
            else $error("completion not answered to a master");
        cmd_cause_a: assert property ($rose(T_REQ[t]) |-> $past(M_REQ) != '0)
            else $error("command without master request");
    end
endmodule

bind xbs_crossbar xbs_crossbar_props props_u (.REF_CLK(REF_CLK), .RESET(RESET), .M_REQ(M_REQ), .M_ACK(M_ACK),
    .T_REQ(T_REQ), .T_ADDR(T_ADDR), .T_ACCEPT(T_ACCEPT), .T_DONE(T_DONE), .SLAVE_BRIDGE_RESET(SLAVE_BRIDGE_RESET));

// File: sim/xbs_target_model.sv
// behavioural model of the five target groups behind the switch
// assumes the switch holds a command until accepted; one clock
`timescale 1ns/1ps
module xbs_target_model
    import xbs_pkg::*;
#(
    parameter logic [31:0] MASK = 32'ha5a5a5a5
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // command side
    input  wire logic [NUM_TARGETS-1:0]        req,
    input  wire logic [NUM_TARGETS*ADDR_W-1:0] addr,
    input  wire logic [NUM_TARGETS-1:0]        we,
    input  wire logic [NUM_TARGETS*DATA_W-1:0] wdata,
    input  wire logic [NUM_TARGETS-1:0]        stall,
    output logic      [NUM_TARGETS-1:0]        accept,
    // completion side
    output logic      [NUM_TARGETS-1:0]        done,
    output logic      [NUM_TARGETS*DATA_W-1:0] rdata
);
    // a stalled target refuses, standing in for a slower clock domain
    assign accept = req & ~stall;
    // one done pulse per taken command; idle data is inverted so it never looks valid.
    // writes echo their data so the bench can see write enable and write data arrive
    always_ff @(posedge clk) begin
        for (int t = 0; t < NUM_TARGETS; t++) begin
            done[t] <= !rst && req[t] && accept[t];
            if (rst) begin
                rdata[t*DATA_W +: DATA_W] <= '0;
            end else if (req[t] && accept[t]) begin
                rdata[t*DATA_W +: DATA_W] <= we[t] ? wdata[t*DATA_W +: DATA_W] : addr[t*ADDR_W +: ADDR_W] ^ MASK;
            end else begin
                rdata[t*DATA_W +: DATA_W] <= ~rdata[t*DATA_W +: DATA_W];
            end
        end
    end
endmodule

// File: sim/xbs_crossbar_bench.sv
// self-checking bench for the crossbar switch
// assumes the target model answers reads with address xor RD_MASK and echoes write data
`timescale 1ns/1ps
module xbs_crossbar_bench
    import xbs_pkg::*;
;
    localparam logic [31:0] RD_MASK = 32'ha5a5a5a5;
    logic         ref_clk = 1'b0;
    logic         reset   = 1'b1;
    logic         ce      = 1'b1;
    logic [3:0]   m_req   = '0;
    logic [3:0]   m_we    = '0;
    logic [127:0] m_addr  = '0;
    logic [127:0] m_wdata = '0;
    logic [3:0]   m_ack;
    logic [127:0] m_rdata;
    logic [4:0]   t_req, t_we, t_accept, t_done;
    logic [4:0]   stall   = '0;
    logic [159:0] t_addr, t_wdata, t_rdata;
    logic         sb_rst;
    logic         rnd_stall = 1'b0;
    int           bad_count = 0;
    int           cmp_count = 0;
    int           lat[4];
    logic [31:0]  rd[4], a[4], wd[4];
    logic [3:0]   we;

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    // slow targets at random when enabled
    always @(negedge ref_clk) stall <= rnd_stall ? 5'($urandom) : 5'h00;

    xbs_crossbar dut_u (.REF_CLK(ref_clk), .RESET(reset), .CE(ce), .M_REQ(m_req), .M_ADDR(m_addr), .M_WE(m_we),
        .M_WDATA(m_wdata), .M_ACK(m_ack), .M_RDATA(m_rdata), .T_REQ(t_req), .T_ADDR(t_addr), .T_WE(t_we),
        .T_WDATA(t_wdata), .T_ACCEPT(t_accept), .T_DONE(t_done), .T_RDATA(t_rdata), .SLAVE_BRIDGE_RESET(sb_rst));
    xbs_target_model #(.MASK(RD_MASK)) model_u (.clk(ref_clk), .rst(reset), .req(t_req), .addr(t_addr),
        .we(t_we), .wdata(t_wdata),
        .stall(stall), .accept(t_accept), .done(t_done), .rdata(t_rdata));

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one master access, request held until its ack, bounded wait
    task automatic access(input int m, input logic [31:0] ad, input logic w, input logic [31:0] d);
        int n = 0;
        @(negedge ref_clk);
        m_req[m] = 1'b1;
        m_addr[m*32 +: 32] = ad;
        m_we[m] = w;
        m_wdata[m*32 +: 32] = d;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (m_ack[m] !== 1'b1 && n < 300);
        if (m_ack[m] !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: no ack for master %0d", $time, m);
            end_of_test();
        end
        lat[m] = n;
        rd[m] = m_rdata[m*32 +: 32];
        @(negedge ref_clk) m_req[m] = 1'b0;
    endtask

    // all four masters start in the same cycle
    task automatic run4();
        for (int i = 0; i < 4; i++) fork
            automatic int k = i;
            access(k, a[k], we[k], wd[k]);
        join_none
        wait fork;
    endtask

    // expected read data from the address map and the wiring
    function automatic logic [31:0] exp_rd(input int m, input logic [31:0] ad, input logic cfg,
                                           input logic w, input logic [31:0] d);
        logic [2:0] t;
        case (ad[31:28])
            4'h0, 4'h1: t = TGT_ONCHIP;
            4'h8, 4'h9: t = TGT_EXTMEM;
            4'h4:       t = TGT_PERIPH;
            4'h6:       t = TGT_DMACFG;
            4'h5:       t = (ad[31:24] >= 8'h54 && ad[31:24] <= 8'h56) ? TGT_AUDIO : TGT_NONE;
            default:    t = TGT_NONE;
        endcase
        if (ad == 32'h40000024) return {31'h0, cfg};
        if (t == TGT_NONE || (m == 1 && t != TGT_EXTMEM) || (m == 0 && t == TGT_ONCHIP)) return '0;
        return w ? d : ad ^ RD_MASK;
    endfunction

    // random address over every region; low nibble clear keeps off the config register
    function automatic logic [31:0] rnd_addr();
        logic [7:0] top[8] = '{8'h00, 8'h10, 8'h47, 8'h55, 8'h61, 8'h80, 8'h90, 8'hf0};
        return {top[$urandom % 8], 20'($urandom), 4'h0};
    endfunction

    initial begin
        void'($urandom(46829));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) reset = 1'b0;
        check32({31'h0, sb_rst}, 32'h1, "bridge reset after reset");
        access(0, 32'h40000024, 1'b0, 32'h0);
        check32(rd[0], 32'h1, "config read");
        // dma to on-chip memory waits until software releases the bridge
        fork
            access(2, 32'h10000040, 1'b0, 32'h0);
            begin
                repeat (8) @(posedge ref_clk);
                access(0, 32'h40000024, 1'b1, 32'h0);
            end
        join
        check32(32'(lat[2] > 10), 32'h1, "on-chip stall");
        check32(rd[2], 32'h10000040 ^ RD_MASK, "on-chip read");
        check32({31'h0, sb_rst}, 32'h0, "bridge released");
        access(0, 32'h40000024, 1'b0, 32'h0);
        check32(rd[0], 32'h0, "config read back");
        // distinct targets run side by side
        a = '{32'h47000000, 32'h80000100, 32'h54000000, 32'h61000000};
        we = 4'h0;
        wd = '{default: 32'h0};
        run4();
        // bridge fill, bridge output stage, target take, completion: four edges each
        for (int i = 0; i < 4; i++) begin
            check32(32'(lat[i]), 32'h4, "parallel latency");
            check32(rd[i], exp_rd(i, a[i], 1'b0, 1'b0, 32'h0), "parallel read");
        end
        // all four contend for external memory
        a = '{32'h80000010, 32'h90000020, 32'h80000030, 32'h80000040};
        run4();
        check32(32'(lat[0] < lat[2]), 32'h1, "cpu before high dma");
        check32(32'(lat[2] < lat[3]), 32'h1, "high dma before low dma");
        check32(32'(lat[3] < lat[1]), 32'h1, "fill last at external memory");
        // three ranks on the peripheral bus
        a = '{32'h47000010, 32'h80000050, 32'h42000000, 32'h48000000};
        run4();
        check32(32'(lat[0] < lat[2] && lat[2] < lat[3]), 32'h1, "peripheral ranks");
        // clock enable low before the take: three lost edges add three cycles
        fork
            access(3, 32'h61000000, 1'b0, 32'h0);
            begin
                @(negedge ref_clk) ce = 1'b0;
                repeat (3) @(negedge ref_clk);
                ce = 1'b1;
            end
        join
        check32(32'(lat[3]), 32'h7, "frozen latency");
        check32(rd[3], 32'h61000000 ^ RD_MASK, "frozen read");
        // random traffic against slow targets
        rnd_stall = 1'b1;
        repeat (40) begin
            for (int i = 0; i < 4; i++) begin
                a[i] = rnd_addr();
                wd[i] = $urandom;
            end
            we = 4'($urandom);
            run4();
            for (int i = 0; i < 4; i++) begin
                check32(rd[i], exp_rd(i, a[i], 1'b0, we[i], wd[i]), "random access");
            end
        end
        rnd_stall = 1'b0;
        end_of_test();
    end
endmodule
